// ### wdt_pkg.sv
// Constants, register map and encodings for the watchdog reset timer.
// Assumes a single 50 MHz core clock and a 32-bit classic Wishbone slave port.
package wdt_pkg;

  // ****************************************
  // Clock and timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 20;
  localparam int RESET_PULSE_NS = 1000;
  localparam int RESET_PULSE_CYCLES = (RESET_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [5:0] RESET_PULSE_LAST = 6'(RESET_PULSE_CYCLES - 1);

  // ****************************************
  // Register byte offsets
  // ****************************************
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_COUNT = 8'h04;
  localparam logic [7:0] OFS_COMMAND = 8'h08;
  localparam logic [7:0] OFS_IRQ_STATUS = 8'h0c;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;

  // ****************************************
  // Control register fields and reset values
  // ****************************************
  localparam int CTL_PRESCALE_BIT = 0;
  localparam int CTL_OVF_BIT = 1;
  localparam int CTL_SOFT_BIT = 2;
  localparam int CTL_SHORT_BIT = 3;
  localparam int CTL_LONG_BIT = 4;
  localparam int CTL_RELOAD_LSB = 8;
  localparam int CTL_RELOAD_MSB = 15;
  localparam logic [15:0] CTL_RST_PIN = 16'h001c;
  localparam logic [15:0] CTL_RST_SOFT = 16'h0004;
  localparam logic [15:0] CTL_RST_WDOG = 16'h0006;

  // ****************************************
  // Counter and prescaler
  // ****************************************
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] COUNT_MAX = 16'hffff;
  localparam int PRE_DIV_FAST = 2;
  localparam int PRE_DIV_SLOW = 128;
  localparam logic [6:0] PRE_LAST_FAST = 7'(PRE_DIV_FAST - 1);
  localparam logic [6:0] PRE_LAST_SLOW = 7'(PRE_DIV_SLOW - 1);

  // ****************************************
  // Command codes (low byte of the command register)
  // ****************************************
  localparam logic [7:0] CMD_SERVICE = 8'h01;
  localparam logic [7:0] CMD_END_INIT = 8'h02;
  localparam logic [7:0] CMD_DISABLE = 8'h03;
  localparam logic [7:0] CMD_SOFT_RESET = 8'h04;

  // ****************************************
  // Interrupt status bits
  // ****************************************
  localparam int IRQ_OVF_BIT = 0;
  localparam int IRQ_REFUSED_BIT = 1;
  localparam int IRQ_W = 2;

  typedef enum logic [0:0] {RS_RUN, RS_PULSE} wdt_rst_state_t;

endpackage

// ### wdt_prescaler.sv
// Tick generator dividing the core clock by 2 or by 128.
// Assumes clear and slowSelect are synchronous to core_clk.
`timescale 1ns/10ps
`default_nettype none
module wdt_prescaler (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic slowSelect,
  output logic tick
);
  logic [6:0] div_q;
  logic [6:0] last;

  assign last = slowSelect ? wdt_pkg::PRE_LAST_SLOW : wdt_pkg::PRE_LAST_FAST;
  // Compare with >= so a switch from slow to fast never runs long
  assign tick = (div_q >= last);

  always_ff @(posedge core_clk) begin
    if (rst || clear || tick) begin
      div_q <= 7'h00;
    end else begin
      div_q <= div_q + 7'h01;
    end
  end
endmodule
`default_nettype wire

// ### wdt_counter.sv
// Sixteen bit watchdog up counter with service load and wrap detect.
// Assumes tick is a one-cycle enable from the prescaler.
`timescale 1ns/10ps
`default_nettype none
module wdt_counter (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic load,
  input wire logic [7:0] loadHigh,
  input wire logic tick,
  input wire logic run,
  output logic [15:0] count,
  output logic wrap
);
  logic [15:0] count_q;

  assign count = count_q;
  // Clear is left out on purpose: it is built from wrap one level up
  assign wrap = run && tick && !load && (count_q == wdt_pkg::COUNT_MAX);

  always_ff @(posedge core_clk) begin
    if (rst || clear) begin
      count_q <= wdt_pkg::COUNT_RST;
    end else if (load) begin
      // Service beats a tick in the same cycle
      count_q <= {loadHigh, 8'h00};
    end else if (run && tick) begin
      count_q <= count_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ### wdt_reset_timer.sv
// Watchdog reset timer: Wishbone registers, commands, reset-cause flags,
// reset output sequencing and interrupt.
// Assumes rst is the pin reset, synchronous to core_clk; bus is classic Wishbone.
`timescale 1ns/10ps
`default_nettype none
module wdt_reset_timer (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  input wire logic [3:0] wb_sel_i,
  input wire logic wb_we_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  output logic wb_ack_o,
  output logic irq,
  output logic resetOutputPinN
);

  // ****************************************
  // Bus decode
  // ****************************************
  logic wbAck_q;
  logic [31:0] wbDat_q;
  logic busReq;
  logic busWr;
  logic [7:0] wordAdr;
  logic wrCtl;
  logic wrCmd;
  logic wrCount;
  logic wrStat;
  logic wrMask;

  assign busReq = wb_cyc_i && wb_stb_i && !wbAck_q;
  assign busWr = busReq && wb_we_i;
  assign wordAdr = {wb_adr_i[7:2], 2'b00};
  assign wrCtl = busWr && (wordAdr == wdt_pkg::OFS_CONTROL);
  assign wrCount = busWr && (wordAdr == wdt_pkg::OFS_COUNT);
  assign wrCmd = busWr && (wordAdr == wdt_pkg::OFS_COMMAND) && wb_sel_i[0];
  assign wrStat = busWr && (wordAdr == wdt_pkg::OFS_IRQ_STATUS) && wb_sel_i[0];
  assign wrMask = busWr && (wordAdr == wdt_pkg::OFS_IRQ_MASK) && wb_sel_i[0];

  // ****************************************
  // Commands
  // ****************************************
  logic cmdService;
  logic cmdEndInit;
  logic cmdDisable;
  logic cmdSoftReset;
  logic wrap;
  logic intReset;
  logic initDone_q;
  logic enable_q;

  assign cmdService = wrCmd && (wb_dat_i[7:0] == wdt_pkg::CMD_SERVICE);
  assign cmdEndInit = wrCmd && (wb_dat_i[7:0] == wdt_pkg::CMD_END_INIT);
  assign cmdDisable = wrCmd && (wb_dat_i[7:0] == wdt_pkg::CMD_DISABLE);
  assign cmdSoftReset = wrCmd && (wb_dat_i[7:0] == wdt_pkg::CMD_SOFT_RESET);
  // Both internal reset sources restart the timer the same way
  assign intReset = wrap || cmdSoftReset;

  // ****************************************
  // Control register
  // ****************************************
  logic [7:0] ctlReload_q;
  logic ctlPrescale_q;
  logic [3:0] ctlFlags_q;
  logic [15:0] ctlValue;

  // Bits 7:5 reserved and read as zero
  assign ctlValue = {ctlReload_q, 3'b000, ctlFlags_q, ctlPrescale_q};

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctlReload_q <= wdt_pkg::CTL_RST_PIN[wdt_pkg::CTL_RELOAD_MSB:wdt_pkg::CTL_RELOAD_LSB];
      ctlPrescale_q <= wdt_pkg::CTL_RST_PIN[wdt_pkg::CTL_PRESCALE_BIT];
      ctlFlags_q <= wdt_pkg::CTL_RST_PIN[wdt_pkg::CTL_LONG_BIT:wdt_pkg::CTL_OVF_BIT];
    end else if (wrap) begin
      ctlReload_q <= wdt_pkg::CTL_RST_WDOG[wdt_pkg::CTL_RELOAD_MSB:wdt_pkg::CTL_RELOAD_LSB];
      ctlPrescale_q <= wdt_pkg::CTL_RST_WDOG[wdt_pkg::CTL_PRESCALE_BIT];
      ctlFlags_q <= wdt_pkg::CTL_RST_WDOG[wdt_pkg::CTL_LONG_BIT:wdt_pkg::CTL_OVF_BIT];
    end else if (cmdSoftReset) begin
      ctlReload_q <= wdt_pkg::CTL_RST_SOFT[wdt_pkg::CTL_RELOAD_MSB:wdt_pkg::CTL_RELOAD_LSB];
      ctlPrescale_q <= wdt_pkg::CTL_RST_SOFT[wdt_pkg::CTL_PRESCALE_BIT];
      ctlFlags_q <= wdt_pkg::CTL_RST_SOFT[wdt_pkg::CTL_LONG_BIT:wdt_pkg::CTL_OVF_BIT];
    end else begin
      if (wrCtl && wb_sel_i[1]) begin
        ctlReload_q <= wb_dat_i[wdt_pkg::CTL_RELOAD_MSB:wdt_pkg::CTL_RELOAD_LSB];
      end
      if (wrCtl && wb_sel_i[0]) begin
        ctlPrescale_q <= wb_dat_i[wdt_pkg::CTL_PRESCALE_BIT];
      end
      if (cmdEndInit) begin
        ctlFlags_q <= 4'h0;
      end else if (cmdService) begin
        ctlFlags_q[0] <= 1'b0;
      end
    end
  end

  // ****************************************
  // Enable and init window
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst || intReset) begin
      initDone_q <= 1'b0;
    end else if (cmdService || cmdEndInit) begin
      initDone_q <= 1'b1;
    end
  end

  // Idle mode has no input here: counting never pauses for it
  always_ff @(posedge core_clk) begin
    if (rst || intReset) begin
      enable_q <= 1'b1;
    end else if (cmdDisable && !initDone_q) begin
      enable_q <= 1'b0;
    end
  end

  // ****************************************
  // Timer datapath
  // ****************************************
  logic tick;
  logic [15:0] count;

  wdt_prescaler u_prescaler (
    .core_clk(core_clk),
    .rst(rst),
    .clear(intReset),
    .slowSelect(ctlPrescale_q),
    .tick(tick)
  );

  wdt_counter u_counter (
    .core_clk(core_clk),
    .rst(rst),
    .clear(intReset),
    .load(cmdService),
    .loadHigh(ctlReload_q),
    .tick(tick),
    .run(enable_q),
    .count(count),
    .wrap(wrap)
  );

  // ****************************************
  // Reset output sequencer
  // ****************************************
  wdt_pkg::wdt_rst_state_t rstState_q;
  logic [5:0] rstCnt_q;
  logic resetOutN_q;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      rstState_q <= wdt_pkg::RS_PULSE;
      rstCnt_q <= 6'h00;
    end else if (intReset) begin
      rstState_q <= wdt_pkg::RS_PULSE;
      rstCnt_q <= 6'h00;
    end else begin
      unique case (rstState_q)
        wdt_pkg::RS_RUN: begin
          rstCnt_q <= 6'h00;
        end
        wdt_pkg::RS_PULSE: begin
          if (rstCnt_q == wdt_pkg::RESET_PULSE_LAST) begin
            rstState_q <= wdt_pkg::RS_RUN;
          end
          rstCnt_q <= rstCnt_q + 6'h01;
        end
      endcase
    end
  end

  // Low during pin reset and for a fixed pulse after any reset
  always_ff @(posedge core_clk) begin
    if (rst || intReset) begin
      resetOutN_q <= 1'b0;
    end else begin
      resetOutN_q <= (rstState_q == wdt_pkg::RS_RUN);
    end
  end
  assign resetOutputPinN = resetOutN_q;

  // ****************************************
  // Interrupts
  // ****************************************
  logic [wdt_pkg::IRQ_W-1:0] irqStat_q;
  logic [wdt_pkg::IRQ_W-1:0] irqMask_q;
  logic [wdt_pkg::IRQ_W-1:0] irqSet;
  logic irq_q;

  assign irqSet = {cmdDisable && initDone_q, wrap};

  // Status survives internal resets so software can see why; set wins
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqStat_q <= '0;
    end else begin
      irqStat_q <= (irqStat_q & ~(wrStat ? wb_dat_i[wdt_pkg::IRQ_W-1:0] : '0)) | irqSet;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irqMask_q <= '0;
    end else if (wrMask) begin
      irqMask_q <= wb_dat_i[wdt_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(irqStat_q & irqMask_q);
    end
  end
  assign irq = irq_q;

  // ****************************************
  // Bus answer
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (rst) begin
      wbAck_q <= 1'b0;
      wbDat_q <= 32'h0000_0000;
    end else begin
      wbAck_q <= busReq;
      if (busReq && !wb_we_i) begin
        unique case (wordAdr)
          wdt_pkg::OFS_CONTROL: wbDat_q <= {16'h0000, ctlValue};
          wdt_pkg::OFS_COUNT: wbDat_q <= {16'h0000, count};
          wdt_pkg::OFS_IRQ_STATUS: wbDat_q <= {30'h0000_0000, irqStat_q};
          wdt_pkg::OFS_IRQ_MASK: wbDat_q <= {30'h0000_0000, irqMask_q};
          default: wbDat_q <= 32'h0000_0000;
        endcase
      end
    end
  end
  assign wb_ack_o = wbAck_q;
  assign wb_dat_o = wbDat_q;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  count_step_a: assert property (tick && enable_q && !cmdService && !intReset
    && count != wdt_pkg::COUNT_MAX |=> count == $past(count) + 16'h0001)
    else $error("Counter did not step on tick");
  fast_rate_a: assert property ((tick && !ctlPrescale_q && !intReset)
    ##1 (!ctlPrescale_q && !intReset) ##1 (!ctlPrescale_q) |-> tick)
    else $error("Fast prescale not divide by two");
  slow_rate_a: assert property (tick && ctlPrescale_q |=> (!tick || !ctlPrescale_q) [*8])
    else $error("Slow prescale ticked too soon");
  svc_low_a: assert property (cmdService && !intReset |=> count[7:0] == 8'h00)
    else $error("Service left low byte nonzero");
  svc_high_a: assert property (cmdService && !intReset
    |=> count[15:8] == $past(ctlReload_q))
    else $error("Service did not load reload value");
  svc_clear_a: assert property (cmdService && !intReset |=> !ctlFlags_q[0])
    else $error("Service left overflow flag set");
  ovf_pin_a: assert property (wrap |=> !resetOutputPinN [*8])
    else $error("Reset pin not held low after overflow");
  count_ro_a: assert property (wrCount && !tick && !cmdService |=> $stable(count))
    else $error("Write changed count register");
  wdog_val_a: assert property (wrap |=> ctlValue == wdt_pkg::CTL_RST_WDOG)
    else $error("Control value wrong after overflow");
  soft_val_a: assert property (cmdSoftReset && !wrap
    |=> ctlValue == wdt_pkg::CTL_RST_SOFT)
    else $error("Control value wrong after soft reset");
  pin_flags_a: assert property ($fell(rst) |-> ctlFlags_q[3:2] == 2'b11
    && ctlValue[5] == 1'b0)
    else $error("Pin reset flags wrong");
  restart_a: assert property (intReset |=> count == wdt_pkg::COUNT_RST
    && enable_q && !ctlPrescale_q)
    else $error("Timer not restarted after reset");
  late_disable_a: assert property (cmdDisable && initDone_q && !intReset
    |=> enable_q == $past(enable_q))
    else $error("Disable honoured after init end");
  end_init_a: assert property (cmdEndInit && !intReset |=> ctlFlags_q == 4'h0)
    else $error("End of init left flags set");
  wrap_pulse_a: assert property (wrap |=> !wrap)
    else $error("Reset request longer than one cycle");

  cover property (wrap);
  cover property (cmdService ##[1:20] tick);
  cover property (cmdDisable && !initDone_q);
  cover property (cmdSoftReset);

endmodule
`default_nettype wire

// ### test_watchdog_reset_timer.sv
// Self-checking bench for the watchdog reset timer: drives the Wishbone
// port directly and watches the reset output and interrupt pins.
// Assumes the register map and command codes of wdt_pkg.
`timescale 1ns/10ps
`default_nettype none
module test_watchdog_reset_timer;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0;
  logic [31:0] wbDatO;
  logic [3:0] wbSel = 4'h0;
  logic wbWe = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbAck;
  logic irq;
  logic resetOutputPinN;
  int miscompares = 0;
  int checkCount = 0;
  logic [31:0] rd;
  logic [31:0] rd2;
  int n;

  always #(wdt_pkg::CLK_PERIOD_NS / 2) core_clk = ~core_clk;

  wdt_reset_timer dut (
    .core_clk(core_clk),
    .rst(rst),
    .wb_adr_i(wbAdr),
    .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO),
    .wb_sel_i(wbSel),
    .wb_we_i(wbWe),
    .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb),
    .wb_ack_o(wbAck),
    .irq(irq),
    .resetOutputPinN(resetOutputPinN)
  );

  // ****************************************
  // Checks and verdict
  // ****************************************
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", checkCount, miscompares);
    if (miscompares == 0 && checkCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checkCount++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // X on got makes the test unknown, which counts as a miss
  task automatic chkRange(input logic [31:0] got, input int lo, input int hi);
    checkCount++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      miscompares++;
      $display("BAD t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  // ****************************************
  // Classic Wishbone master
  // ****************************************
  task automatic busCycle(input logic [7:0] adr, input logic we, input logic [31:0] dat,
                          input logic [3:0] sel, output logic [31:0] q);
    @(posedge core_clk);
    wbAdr <= adr;
    wbWe <= we;
    wbDatI <= dat;
    wbSel <= sel;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    // No local limit: the watchdog process ends a hung wait
    do begin
      @(posedge core_clk);
    end while (wbAck !== 1'b1);
    q = wbDatO;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] adr, input logic [31:0] dat, input logic [3:0] sel);
    logic [31:0] dummy;
    busCycle(adr, 1'b1, dat, sel, dummy);
  endtask

  task automatic rdReg(input logic [7:0] adr, output logic [31:0] q);
    busCycle(adr, 1'b0, 32'h0, 4'hf, q);
  endtask

  task automatic idle(input int c);
    repeat (c) @(posedge core_clk);
  endtask

  // ****************************************
  // Reset pin observation
  // ****************************************
  task automatic waitLow(output int c);
    c = 0;
    while (resetOutputPinN !== 1'b0 && c < 2000) begin
      @(posedge core_clk);
      c++;
    end
  endtask

  task automatic lowLen(output int c);
    c = 0;
    while (resetOutputPinN === 1'b0 && c < 200) begin
      @(posedge core_clk);
      c++;
    end
  endtask

  // Offsets between the two sampling edges make one tick of slack
  task automatic rateCheck();
    rdReg(wdt_pkg::OFS_COUNT, rd);
    idle(100);
    rdReg(wdt_pkg::OFS_COUNT, rd2);
    chkRange(rd2 - rd, 51, 52);
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    repeat (20) @(posedge core_clk);
    chk({31'h0, resetOutputPinN}, 32'h0);
    rst <= 1'b0;
    lowLen(n);
    chkRange(32'(n), 50, 52);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h0000001c);
    rateCheck();
    wr(wdt_pkg::OFS_COUNT, 32'h00008000, 4'hf);
    rdReg(wdt_pkg::OFS_COUNT, rd);
    chkRange(rd, 0, 32'h00ff);
    rdReg(8'h14, rd);
    chk(rd, 32'h0);
    wr(wdt_pkg::OFS_CONTROL, 32'h0000ffff, 4'h3);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h0000ff1d);
    wr(wdt_pkg::OFS_CONTROL, 32'h0000ab00, 4'h3);
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_SERVICE}, 4'h1);
    rdReg(wdt_pkg::OFS_COUNT, rd);
    chkRange(rd, 32'hab00, 32'hab02);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h0000ab1c);
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_END_INIT}, 4'h1);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h0000ab00);
    // Disable after service is refused; refusal flag exercises the irq path
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_DISABLE}, 4'h1);
    rdReg(wdt_pkg::OFS_IRQ_STATUS, rd);
    chk(rd, 32'h2);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr(wdt_pkg::OFS_IRQ_MASK, 32'h2, 4'h1);
    idle(2);
    chk({31'h0, irq}, 32'h1);
    wr(wdt_pkg::OFS_IRQ_STATUS, 32'h2, 4'h1);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    wr(wdt_pkg::OFS_IRQ_MASK, 32'h1, 4'h1);
    // Overflow: 256 ticks at the fast rate
    wr(wdt_pkg::OFS_CONTROL, 32'h0000ff00, 4'h3);
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_SERVICE}, 4'h1);
    waitLow(n);
    chkRange(32'(n), 500, 530);
    lowLen(n);
    chk(32'(n), 32'(wdt_pkg::RESET_PULSE_CYCLES + 1));
    chk({31'h0, irq}, 32'h1);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h00000006);
    rdReg(wdt_pkg::OFS_IRQ_STATUS, rd);
    chk(rd, 32'h1);
    wr(wdt_pkg::OFS_IRQ_STATUS, 32'h1, 4'h1);
    idle(2);
    chk({31'h0, irq}, 32'h0);
    rateCheck();
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_SERVICE}, 4'h1);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h00000004);
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_END_INIT}, 4'h1);
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h00000000);
    // Software reset, then disable inside the reopened window
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_SOFT_RESET}, 4'h1);
    waitLow(n);
    chkRange(32'(n), 0, 3);
    lowLen(n);
    chk(32'(n), 32'(wdt_pkg::RESET_PULSE_CYCLES + 1));
    rdReg(wdt_pkg::OFS_CONTROL, rd);
    chk(rd, 32'h00000004);
    rateCheck();
    wr(wdt_pkg::OFS_COMMAND, {24'h0, wdt_pkg::CMD_DISABLE}, 4'h1);
    rdReg(wdt_pkg::OFS_COUNT, rd);
    idle(100);
    rdReg(wdt_pkg::OFS_COUNT, rd2);
    chk(rd2, rd);
    rdReg(wdt_pkg::OFS_IRQ_STATUS, rd);
    chk(rd, 32'h0);
    stop_test();
  end

  // Whole run is about 1200 cycles; this only cuts a hang
  initial begin
    repeat (20000) @(posedge core_clk);
    miscompares++;
    stop_test();
  end
endmodule
`default_nettype wire
